// ===== baro_defs.svh
// Offsets, field positions, command codes and timing figures of the sensor readout
`ifndef BARO_DEFS_SVH
`define BARO_DEFS_SVH

`define SLAVE_ADDR        7'h77
`define CTRL_REG_ADDR     8'hff
`define RESULT_REG_ADDR   8'hf6
`define CALIB_ONE_ADDR    8'hf8
`define CALIB_TWO_ADDR    8'hfa
`define CALIB_THREE_ADDR  8'hfc
`define CALIB_FOUR_ADDR   8'hfe
`define UNMAPPED_BYTE     8'h00

`define CTRL_SEL_BIT      2
`define CMD_TEMP_SLOW     8'h6e
`define CMD_TEMP_FAST     8'h6a
`define CMD_PRES_SLOW     8'hf4
`define CMD_PRES_FAST     8'hf0

`define TEMP_RES_BITS     13

`define CONV_PRES_TIME_US 34000
`define CONV_TEMP_TIME_US 9500
`define INT_HZ_SLOW       16384
`define INT_HZ_FAST       15625
`define PRESCALE_SLOW     2
`define PRESCALE_FAST     64
`define US_PER_S          1000000

`endif

// ===== baro_pkg.sv
// Types shared by the sensor readout modules
package baro_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ACK_ADDR = 3'h3,
    ST_WR_BYTE  = 3'h2,
    ST_ACK_WR   = 3'h6,
    ST_RD_BYTE  = 3'h7,
    ST_RD_ACK   = 3'h5
  } i2c_state_t;

  typedef logic [15:0] word_t;

endpackage

// ===== calib_rom.sv
// Per-unit calibration store: four packed 16-bit words, registered read
`timescale 1ns/100ps
`include "baro_defs.svh"

module calib_rom #(
  parameter logic [13:0] COEF_ONE   = 14'h2132,
  parameter logic [8:0]  COEF_TWO   = 9'h100,
  parameter logic [8:0]  COEF_THREE = 9'h103,
  parameter logic [12:0] COEF_FOUR  = 13'h116d,
  parameter logic [6:0]  COEF_FIVE  = 7'h3c,
  parameter logic [11:0] COEF_SIX   = 12'hb37
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  input  wire logic [1:0]           i_addr,
  output logic      [15:0]          o_rd_data
);

  // Coefficients are split across word boundaries exactly as the host unpacks them
  function automatic baro_pkg::word_t pack_word(input logic [1:0] idx);
    unique case (idx)
      2'h0: pack_word = {COEF_TWO[1:0], COEF_ONE};
      2'h1: pack_word = {COEF_TWO[8:2], COEF_THREE};
      2'h2: pack_word = {COEF_FIVE[2:0], COEF_FOUR};
      2'h3: pack_word = {COEF_FIVE[6:3], COEF_SIX};
    endcase
  endfunction

  baro_pkg::word_t rd_d;
  baro_pkg::word_t rd_q;

  always_comb begin
    rd_d = pack_word(i_addr);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rd_q <= 16'h0000;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign o_rd_data = rd_q;

endmodule

// ===== conv_timer.sv
// Conversion clock prescaler and conversion duration timer
`timescale 1ns/100ps
`include "baro_defs.svh"

module conv_timer #(
  parameter int TICK_W = 10
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  input  wire logic                 i_clear,
  input  wire logic                 i_conv_clk,
  input  wire logic                 i_clk_sel,
  input  wire logic                 i_start,
  input  wire logic                 i_pressure,
  output logic                      o_busy,
  output logic                      o_done
);

  // Longest time: round down to whole internal ticks
  localparam int PRES_SLOW = `CONV_PRES_TIME_US * `INT_HZ_SLOW / `US_PER_S;
  localparam int TEMP_SLOW = `CONV_TEMP_TIME_US * `INT_HZ_SLOW / `US_PER_S;
  localparam int PRES_FAST = `CONV_PRES_TIME_US * `INT_HZ_FAST / `US_PER_S;
  localparam int TEMP_FAST = `CONV_TEMP_TIME_US * `INT_HZ_FAST / `US_PER_S;
  localparam logic [5:0] DIV_SLOW = 6'(`PRESCALE_SLOW - 1);
  localparam logic [5:0] DIV_FAST = 6'(`PRESCALE_FAST - 1);

  function automatic logic [TICK_W-1:0] tick_limit(input logic pres, input logic sel);
    if (pres) begin
      tick_limit = sel ? TICK_W'(PRES_FAST - 1) : TICK_W'(PRES_SLOW - 1);
    end else begin
      tick_limit = sel ? TICK_W'(TEMP_FAST - 1) : TICK_W'(TEMP_SLOW - 1);
    end
  endfunction

  logic              clk_prev_q, clk_prev_d;
  logic [5:0]        pre_q, pre_d;
  logic [TICK_W-1:0] tick_q, tick_d;
  logic              busy_q, busy_d;
  logic              pres_q, pres_d;
  logic              sel_q, sel_d;
  logic              done_q, done_d;
  logic              conv_rise;

  // The conversion clock is only counted while it toggles; a stopped clock stalls the timer
  assign conv_rise = i_conv_clk & ~clk_prev_q;

  always_comb begin
    clk_prev_d = i_conv_clk;
    pre_d      = pre_q;
    tick_d     = tick_q;
    busy_d     = busy_q;
    pres_d     = pres_q;
    sel_d      = sel_q;
    done_d     = 1'b0;
    if (i_clear) begin
      pre_d  = 6'h00;
      tick_d = '0;
      busy_d = 1'b0;
      pres_d = 1'b0;
      sel_d  = 1'b0;
    end else if (!busy_q) begin
      if (i_start) begin
        busy_d = 1'b1;
        pres_d = i_pressure;
        sel_d  = i_clk_sel;
        pre_d  = 6'h00;
        tick_d = '0;
      end
    end else if (conv_rise) begin
      if (pre_q == (sel_q ? DIV_FAST : DIV_SLOW)) begin
        pre_d = 6'h00;
        if (tick_q == tick_limit(pres_q, sel_q)) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end else begin
          tick_d = tick_q + TICK_W'(1);
        end
      end else begin
        pre_d = pre_q + 6'h01;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      clk_prev_q <= 1'b0;
      pre_q      <= 6'h00;
      tick_q     <= '0;
      busy_q     <= 1'b0;
      pres_q     <= 1'b0;
      sel_q      <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      clk_prev_q <= clk_prev_d;
      pre_q      <= pre_d;
      tick_q     <= tick_d;
      busy_q     <= busy_d;
      pres_q     <= pres_d;
      sel_q      <= sel_d;
      done_q     <= done_d;
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;

  AST_CONV_BOUND: assert property (@(posedge i_mclk) disable iff (i_reset)
    busy_q |-> tick_q <= tick_limit(pres_q, sel_q))
    else $error("conversion ran past its time limit");

  AST_PRESCALE: assert property (@(posedge i_mclk) disable iff (i_reset)
    busy_q |-> pre_q <= (sel_q ? DIV_FAST : DIV_SLOW))
    else $error("prescaler exceeded selected divisor");

  AST_DONE_PULSE: assert property (@(posedge i_mclk) disable iff (i_reset)
    done_q |-> !busy_q ##1 !done_q)
    else $error("done is not a single pulse");

endmodule

// ===== baro_sensor_serial_readout.sv
// Two-wire serial slave of the pressure/temperature sensor with control and readout words
`timescale 1ns/100ps
`include "baro_defs.svh"

module baro_sensor_serial_readout (
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  input  wire logic                 i_clear_n,
  input  wire logic                 i_conv_clk,
  input  wire logic                 i_scl_in,
  input  wire logic                 i_sda_in,
  input  wire logic [15:0]          i_adc_temperature,
  input  wire logic [15:0]          i_adc_pressure,
  output logic                      o_scl_out,
  output logic                      o_scl_oe,
  output logic                      o_sda_out,
  output logic                      o_sda_oe,
  output logic                      o_conv_start,
  output logic                      o_conv_pressure,
  output logic                      o_conv_busy
);

  localparam logic [15:0] TEMP_KEEP = 16'hffff << (16 - `TEMP_RES_BITS);

  // A control value is a command only in one of its four documented encodings
  function automatic logic is_command(input logic [7:0] v);
    is_command = (v == `CMD_TEMP_SLOW) || (v == `CMD_TEMP_FAST) ||
                 (v == `CMD_PRES_SLOW) || (v == `CMD_PRES_FAST);
  endfunction

  function automatic logic is_pressure(input logic [7:0] v);
    is_pressure = (v == `CMD_PRES_SLOW) || (v == `CMD_PRES_FAST);
  endfunction

  baro_pkg::i2c_state_t state_q, state_d;
  logic             scl_prev_q, scl_prev_d;
  logic             sda_prev_q, sda_prev_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [7:0]       sr_q, sr_d;
  logic             rw_q, rw_d;
  logic             drive_q, drive_d;
  logic [1:0]       byte_idx_q, byte_idx_d;
  logic [7:0]       ptr_q, ptr_d;
  logic             mack_q, mack_d;
  logic             lo_q, lo_d;
  logic [7:0]       tx_q, tx_d;
  logic             clk_sel_q, clk_sel_d;
  logic             start_q, start_d;
  logic             kind_q, kind_d;
  logic             start_evt, stop_evt, scl_rise, scl_fall;
  logic             clear;
  logic [7:0]       sr_next;
  baro_pkg::word_t  calib_word;
  baro_pkg::word_t  rd_word;
  baro_pkg::word_t  temp_q, temp_d;
  baro_pkg::word_t  pres_q, pres_d;
  logic             last_pres_q, last_pres_d;
  logic             conv_done;

  assign clear     = ~i_clear_n;
  assign start_evt = scl_prev_q & i_scl_in & sda_prev_q & ~i_sda_in;
  assign stop_evt  = scl_prev_q & i_scl_in & ~sda_prev_q & i_sda_in;
  assign scl_rise  = ~scl_prev_q & i_scl_in;
  assign scl_fall  = scl_prev_q & ~i_scl_in;
  assign sr_next   = {sr_q[6:0], i_sda_in};

  calib_rom u_calib_rom (
    .i_mclk    (i_mclk),
    .i_reset   (i_reset),
    .i_addr    (ptr_q[2:1]),
    .o_rd_data (calib_word)
  );

  conv_timer u_conv_timer (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_clear    (clear),
    .i_conv_clk (i_conv_clk),
    .i_clk_sel  (clk_sel_q),
    .i_start    (start_q),
    .i_pressure (kind_q),
    .o_busy     (o_conv_busy),
    .o_done     (conv_done)
  );

  // Readout word selected by the pointer; unmapped pointers read as zero
  always_comb begin
    unique case (ptr_q)
      `RESULT_REG_ADDR:  rd_word = last_pres_q ? pres_q : temp_q;
      `CALIB_ONE_ADDR,
      `CALIB_TWO_ADDR,
      `CALIB_THREE_ADDR,
      `CALIB_FOUR_ADDR:  rd_word = calib_word;
      default:           rd_word = {`UNMAPPED_BYTE, `UNMAPPED_BYTE};
    endcase
  end

  // Serial protocol engine; outputs change one cycle after the sampled clock fall
  always_comb begin
    state_d    = state_q;
    scl_prev_d = i_scl_in;
    sda_prev_d = i_sda_in;
    cnt_d      = cnt_q;
    sr_d       = sr_q;
    rw_d       = rw_q;
    drive_d    = drive_q;
    byte_idx_d = byte_idx_q;
    ptr_d      = ptr_q;
    mack_d     = mack_q;
    lo_d       = lo_q;
    tx_d       = tx_q;
    clk_sel_d  = clk_sel_q;
    start_d    = 1'b0;
    kind_d     = kind_q;
    if (clear) begin
      state_d    = baro_pkg::ST_IDLE;
      cnt_d      = 4'h0;
      sr_d       = 8'h00;
      rw_d       = 1'b0;
      drive_d    = 1'b0;
      byte_idx_d = 2'h0;
      ptr_d      = 8'h00;
      mack_d     = 1'b0;
      lo_d       = 1'b0;
      tx_d       = 8'h00;
      clk_sel_d  = 1'b0;
      kind_d     = 1'b0;
    end else if (stop_evt) begin
      state_d = baro_pkg::ST_IDLE;
      drive_d = 1'b0;
    end else if (start_evt) begin
      state_d = baro_pkg::ST_ADDR;
      cnt_d   = 4'h0;
      drive_d = 1'b0;
    end else begin
      unique case (state_q)
        baro_pkg::ST_IDLE: begin
          drive_d = 1'b0;
        end
        baro_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sr_d  = sr_next;
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            if (sr_q[7:1] == `SLAVE_ADDR) begin
              state_d = baro_pkg::ST_ACK_ADDR;
              drive_d = 1'b1;
              rw_d    = sr_q[0];
            end else begin
              state_d = baro_pkg::ST_IDLE;
            end
          end
        end
        baro_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              state_d = baro_pkg::ST_RD_BYTE;
              tx_d    = rd_word[15:8];
              lo_d    = 1'b1;
              drive_d = ~rd_word[15];
            end else begin
              state_d    = baro_pkg::ST_WR_BYTE;
              byte_idx_d = 2'h0;
              drive_d    = 1'b0;
            end
          end
        end
        baro_pkg::ST_WR_BYTE: begin
          if (scl_rise) begin
            sr_d  = sr_next;
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            state_d = baro_pkg::ST_ACK_WR;
            drive_d = 1'b1;
            if (byte_idx_q == 2'h0) begin
              ptr_d = sr_q;
            end else if (byte_idx_q == 2'h1 && ptr_q == `CTRL_REG_ADDR) begin
              clk_sel_d = sr_q[`CTRL_SEL_BIT];
              if (is_command(sr_q) && !o_conv_busy) begin
                start_d = 1'b1;
                kind_d  = is_pressure(sr_q);
              end
            end
            if (byte_idx_q != 2'h3) begin
              byte_idx_d = byte_idx_q + 2'h1;
            end
          end
        end
        baro_pkg::ST_ACK_WR: begin
          if (scl_fall) begin
            state_d = baro_pkg::ST_WR_BYTE;
            cnt_d   = 4'h0;
            drive_d = 1'b0;
          end
        end
        baro_pkg::ST_RD_BYTE: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              state_d = baro_pkg::ST_RD_ACK;
              drive_d = 1'b0;
            end else begin
              drive_d = ~tx_q[3'(4'h7 - cnt_q)];
            end
          end
        end
        baro_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            mack_d = ~i_sda_in;
          end else if (scl_fall) begin
            if (mack_q) begin
              state_d = baro_pkg::ST_RD_BYTE;
              cnt_d   = 4'h0;
              tx_d    = lo_q ? rd_word[7:0] : rd_word[15:8];
              lo_d    = ~lo_q;
              drive_d = lo_q ? ~rd_word[7] : ~rd_word[15];
            end else begin
              state_d = baro_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_d = baro_pkg::ST_IDLE;
          drive_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_q    <= baro_pkg::ST_IDLE;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      cnt_q      <= 4'h0;
      sr_q       <= 8'h00;
      rw_q       <= 1'b0;
      drive_q    <= 1'b0;
      byte_idx_q <= 2'h0;
      ptr_q      <= 8'h00;
      mack_q     <= 1'b0;
      lo_q       <= 1'b0;
      tx_q       <= 8'h00;
      clk_sel_q  <= 1'b0;
      start_q    <= 1'b0;
      kind_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
      cnt_q      <= cnt_d;
      sr_q       <= sr_d;
      rw_q       <= rw_d;
      drive_q    <= drive_d;
      byte_idx_q <= byte_idx_d;
      ptr_q      <= ptr_d;
      mack_q     <= mack_d;
      lo_q       <= lo_d;
      tx_q       <= tx_d;
      clk_sel_q  <= clk_sel_d;
      start_q    <= start_d;
      kind_q     <= kind_d;
    end
  end

  // Results; a read during conversion still returns the previous word
  always_comb begin
    temp_d      = temp_q;
    pres_d      = pres_q;
    last_pres_d = last_pres_q;
    if (clear) begin
      temp_d      = 16'h0000;
      pres_d      = 16'h0000;
      last_pres_d = 1'b0;
    end else if (conv_done) begin
      last_pres_d = kind_q;
      if (kind_q) begin
        pres_d = i_adc_pressure;
      end else begin
        temp_d = i_adc_temperature & TEMP_KEEP;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      temp_q      <= 16'h0000;
      pres_q      <= 16'h0000;
      last_pres_q <= 1'b0;
    end else begin
      temp_q      <= temp_d;
      pres_q      <= pres_d;
      last_pres_q <= last_pres_d;
    end
  end

  // Open drain: output level is always low, enable means pulling the wire low
  assign o_sda_out       = 1'b0;
  assign o_sda_oe        = drive_q;
  assign o_scl_out       = 1'b0;
  assign o_scl_oe        = 1'b0;
  assign o_conv_start    = start_q;
  assign o_conv_pressure = kind_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  AST_SDA_LOW_ONLY: assert property (!o_sda_out && !o_scl_oe)
    else $error("serial lines driven other than low");
  AST_ADDR_ACK: assert property (state_q == baro_pkg::ST_ACK_ADDR |-> o_sda_oe)
    else $error("address acknowledge not pulled low");
  AST_WRITE_ACK: assert property (state_q == baro_pkg::ST_ACK_WR |-> o_sda_oe)
    else $error("write byte not acknowledged");
  AST_IDLE_RELEASE: assert property (state_q == baro_pkg::ST_IDLE |-> !o_sda_oe)
    else $error("data line held while not addressed");
  AST_CHANGE_LOW: assert property ($changed(o_sda_oe) |-> !$past(i_scl_in) || $past(stop_evt) || $past(start_evt))
    else $error("data line changed while clock high");
  AST_START_ADDR: assert property (start_evt && !stop_evt && i_clear_n |=> state_q == baro_pkg::ST_ADDR)
    else $error("start condition not taken");
  AST_STOP_IDLE: assert property (stop_evt |=> state_q == baro_pkg::ST_IDLE ##1 !o_sda_oe)
    else $error("stop condition not taken");
  AST_CLEAR: assert property (!i_clear_n |=> state_q == baro_pkg::ST_IDLE && !clk_sel_q && temp_q == 16'h0000)
    else $error("clear did not restore initial state");
  AST_CMD_START: assert property (start_q |-> $past(ptr_q) == `CTRL_REG_ADDR ##1 o_conv_busy)
    else $error("conversion start without control write");
  AST_TEMP_RES: assert property (temp_q[2:0] == 3'h0)
    else $error("temperature word carries unresolved bits");
  AST_SEL_TRACK: assert property (start_q |-> clk_sel_q == $past(sr_q[`CTRL_SEL_BIT]))
    else $error("prescaler select not updated");

endmodule

// ===== host_master_model.sv
// Two-wire bus master model standing in for the host controller
`timescale 1ns/100ps
module host_master_model (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output logic      o_scl_oe,
  output logic      o_sda_oe
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // Data moves mid low phase and is sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    o_scl_oe <= 1'b1;
    wait_n(2);
    o_sda_oe <= ~b;
    wait_n(2);
    o_scl_oe <= 1'b0;
    wait_n(2);
    s = i_sda;
    wait_n(2);
  endtask

  // Data falls while the clock is high; also serves as repeated start
  task automatic start_cond();
    o_scl_oe <= 1'b1;
    wait_n(2);
    o_sda_oe <= 1'b0;
    wait_n(2);
    o_scl_oe <= 1'b0;
    wait_n(4);
    o_sda_oe <= 1'b1;
    wait_n(4);
  endtask

  // Data rises while the clock is high
  task automatic stop_cond();
    o_scl_oe <= 1'b1;
    wait_n(2);
    o_sda_oe <= 1'b1;
    wait_n(2);
    o_scl_oe <= 1'b0;
    wait_n(4);
    o_sda_oe <= 1'b0;
    wait_n(4);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Last byte gets a not-acknowledge, earlier ones an acknowledge
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, s);
  endtask

  // Address byte, pointer and value, each acknowledged, then stop
  task automatic write_cmd(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] val,
                           output logic [2:0] slave_ack);
    start_cond();
    send_byte(dev, slave_ack[2]);
    send_byte(ptr, slave_ack[1]);
    send_byte(val, slave_ack[0]);
    stop_cond();
  endtask

  // Pointer write, repeated start, read address, high byte first
  task automatic read_word(input logic [7:0] ptr, output logic [15:0] w);
    logic a;
    start_cond();
    send_byte(8'hee, a);
    send_byte(ptr, a);
    start_cond();
    send_byte(8'hef, a);
    recv_byte(1'b0, w[15:8]);
    recv_byte(1'b1, w[7:0]);
    stop_cond();
  endtask
endmodule

// ===== baro_sensor_serial_readout_tb_top.sv
// Self-checking bench of the sensor readout driven by the bus master model
`timescale 1ns/100ps
module baro_sensor_serial_readout_tb_top;
  localparam logic [13:0] C1 = 14'h2132;
  localparam logic [8:0]  C2 = 9'h100;
  localparam logic [8:0]  C3 = 9'h103;
  localparam logic [12:0] C4 = 13'h116d;
  localparam logic [6:0]  C5 = 7'h3c;
  localparam logic [11:0] C6 = 12'hb37;
  localparam logic [15:0] CAL [4] = '{{C2[1:0], C1}, {C2[8:2], C3}, {C5[2:0], C4}, {C5[6:3], C6}};
  localparam logic [7:0]  CMDS [4] = '{8'h6e, 8'h6a, 8'hf4, 8'hf0};
  logic        i_mclk, i_reset, i_clear_n, i_conv_clk;
  logic [15:0] adc_t, adc_p;
  logic        scl_out, scl_oe, sda_out, sda_oe, conv_start, conv_pres, conv_busy;
  logic        host_scl_oe, host_sda_oe, prev_scl, prev_oe;
  int          err_total, checked, cycles, starts, line_viol, busy_len;
  wire         scl = ~(host_scl_oe | scl_oe);
  wire         sda = ~(host_sda_oe | sda_oe);

  baro_sensor_serial_readout u_baro_sensor_serial_readout (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_clear_n(i_clear_n), .i_conv_clk(i_conv_clk), .i_scl_in(scl), .i_sda_in(sda),
    .i_adc_temperature(adc_t), .i_adc_pressure(adc_p), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_conv_start(conv_start),
    .o_conv_pressure(conv_pres), .o_conv_busy(conv_busy));
  host_master_model u_host_master_model (.i_mclk(i_mclk), .i_sda(sda), .o_scl_oe(host_scl_oe),
    .o_sda_oe(host_sda_oe));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // Conversion clock runs free, so it never stops mid-conversion
  always @(posedge i_mclk) begin
    i_conv_clk <= ~i_conv_clk;
    cycles++;
    prev_scl <= scl;
    prev_oe <= sda_oe;
    if (conv_start === 1'b1) starts++;
    // Span restarts at each accepted command, so it covers the whole conversion
    if (conv_start === 1'b1) begin
      busy_len = 0;
    end else if (conv_busy === 1'b1) begin
      busy_len++;
    end
    if ((scl_oe | scl_out | sda_out) !== 1'b0) line_viol++;
    // Reset time is skipped: the data enable may be unknown before the first edge
    if (i_reset === 1'b0 && scl === 1'b1 && prev_scl === 1'b1 && sda_oe !== prev_oe) line_viol++;
    // Tests need about 96k cycles, most of them in the long pressure conversion
    if (cycles == 100000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    logic [2:0]  slave_ack;
    logic [15:0] w, et, ep;
    int          s0, n, dv;
    logic [15:0] cw [4];
    int          coef_two, coef_three, derived_coef_one, derived_coef_two;
    {i_reset, i_clear_n, i_conv_clk, prev_scl, prev_oe} = 5'h1b;
    {adc_t, adc_p} = 32'h0;
    {err_total, checked, cycles, starts, line_viol, busy_len} = '0;
    repeat (10) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    u_host_master_model.read_word(8'hf6, w);
    check("result after reset", w, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      u_host_master_model.read_word(8'hf8 + 8'(2 * i), w);
      check("calibration word", w, CAL[i]);
      cw[i] = w;
    end
    // Host unpacks its coefficients from the words read and derives two more
    coef_two = int'({cw[1][15:9], cw[0][15:14]});
    coef_three = int'(cw[1][8:0]);
    derived_coef_one = ((coef_three - 2063) * -28006) / 2048 - 20108;
    derived_coef_two = ((coef_two - 475) * derived_coef_one / 16) / (coef_three - 2063);
    check("derived coefficient one", 16'(derived_coef_one), 16'h11d1);
    check("derived coefficient two", 16'(derived_coef_two), 16'h0022);
    u_host_master_model.read_word(8'h10, w);
    check("unmapped pointer", w, 16'h0000);
    s0 = starts;
    u_host_master_model.write_cmd(8'hfe, 8'hff, 8'hf4, slave_ack);
    check("foreign slave_ack", {13'h0, slave_ack}, 16'h0000);
    check("foreign starts", 16'(starts - s0), 16'h0000);
    $display("test readout and addressing done");
    for (int i = 0; i < 4; i++) begin
      et = 16'h a5c7 + 16'(i * 16'h0929);
      ep = 16'h3c5a + 16'(i * 16'h1137);
      adc_t <= et;
      adc_p <= ep;
      s0 = starts;
      u_host_master_model.write_cmd(8'hee, 8'hff, CMDS[i], slave_ack);
      check("command slave_ack", {13'h0, slave_ack}, 16'h0007);
      check("start pulses", 16'(starts - s0), 16'h0001);
      check("conversion kind", {15'h0, conv_pres}, {15'h0, CMDS[i][7]});
      // Wait for busy to drop before reading the result
      for (int k = 0; k < 80000 && conv_busy !== 1'b0; k++) @(posedge i_mclk);
      dv = CMDS[i][2] ? 64 : 2;
      n = CMDS[i][7] ? (CMDS[i][2] ? 531 : 557) : (CMDS[i][2] ? 148 : 155);
      check("busy span", {15'h0, busy_len >= (n - 1) * dv * 2 && busy_len <= (n + 1) * dv * 2 + 8},
            16'h0001);
      u_host_master_model.read_word(8'hf6, w);
      check("result word", w, CMDS[i][7] ? ep : (et & 16'hfff8));
    end
    $display("test conversions done");
    s0 = starts;
    u_host_master_model.write_cmd(8'hee, 8'hff, 8'hf0, slave_ack);
    u_host_master_model.write_cmd(8'hee, 8'hff, 8'h6a, slave_ack);
    check("kind kept while busy", {15'h0, conv_pres}, 16'h0001);
    check("no start while busy", 16'(starts - s0), 16'h0001);
    i_clear_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_clear_n <= 1'b1;
    @(posedge i_mclk);
    check("busy after clear", {15'h0, conv_busy}, 16'h0000);
    u_host_master_model.read_word(8'hf6, w);
    check("result after clear", w, 16'h0000);
    u_host_master_model.write_cmd(8'hee, 8'hff, 8'h55, slave_ack);
    check("no start on other value", 16'(starts - s0), 16'h0001);
    check("line misuse", 16'(line_viol), 16'h0000);
    $display("test clear and line use done");
    close_out();
  end
endmodule
